// File: rtl/controller_fault_status_word.sv
// Purpose: Global fault and status word of a multi-axis motion controller
// Assumes: Event inputs come from logic on clk; medium and abort pins are asynchronous
// Notes:   Word lives in flip-flops only and is read over a plain read port
`timescale 1ns/1ns
`include "fault_status_consts.svh"

module controller_fault_status_word
  import fault_status_pkg::*;
#(
  parameter int unsigned STORE_CAP_W = 24
)
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   reset_cmd,
  input  wire logic                   marker_folder_present,
  input  wire logic                   abort_all_in,
  input  wire logic                   save_cmd,
  input  wire logic [STORE_CAP_W-1:0] program_size,
  input  wire logic [STORE_CAP_W-1:0] flash_capacity,
  input  wire logic                   buffer_ram_overflow_evt,
  input  wire logic                   missing_clock_evt,
  input  wire logic                   system_file_setting_evt,
  input  wire logic                   saved_settings_evt,
  input  wire logic                   project_read_evt,
  input  wire logic                   rt_watchdog_evt,
  input  wire logic                   bg_watchdog_evt,
  input  wire logic                   status_wr,
  input  wire logic [31:0]            status_wdata,
  output logic      [31:0]            global_fault_status,
  output logic                        save_go,
  output logic                        factory_restore
);

  // Two-flop synchronisers for the pin inputs
  logic [1:0] marker_sync_reg;
  logic [1:0] marker_sync_next;
  logic [1:0] abort_sync_reg;
  logic [1:0] abort_sync_next;

  always_comb
  begin
    marker_sync_next = {marker_sync_reg[0], marker_folder_present};
    abort_sync_next  = {abort_sync_reg[0], abort_all_in};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      marker_sync_reg <= 2'h0;
      abort_sync_reg  <= 2'h0;
    end
    else
    begin
      marker_sync_reg <= marker_sync_next;
      abort_sync_reg  <= abort_sync_next;
    end
  end

  // Startup: medium seen only once, after power-on; later insertion has no effect
  startup_state_t state_reg;
  startup_state_t state_next;
  logic           restore_next;
  logic           restore_reg;
  logic [1:0]     settle_reg;
  logic [1:0]     settle_next;

  always_comb
  begin
    state_next   = state_reg;
    restore_next = 1'b0;
    settle_next  = settle_reg;
    unique case (state_reg)
      ST_STRAP:
      begin
        // Synchroniser is cleared by reset, so wait until the pin has crossed both flops
        if (settle_reg != `MARKER_SETTLE)
        begin
          settle_next = 2'(settle_reg + 2'h1);
          state_next  = ST_STRAP;
        end
        else
        begin
          state_next = marker_sync_reg[1] ? ST_RESTORE : ST_RUN;
        end
      end
      ST_RESTORE:
      begin
        restore_next = 1'b1;
        state_next   = ST_RUN;
      end
      ST_RUN:
      begin
        state_next = ST_RUN;
      end
      default:
      begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg   <= ST_STRAP;
      restore_reg <= 1'b0;
      settle_reg  <= 2'h0;
    end
    else
    begin
      state_reg   <= state_next;
      restore_reg <= restore_next;
      settle_reg  <= settle_next;
    end
  end

  // Sticky fault bits; reset command or power loss clears them, a set wins over the reset command
  logic [15:0] flags_reg;
  logic [15:0] flags_next;
  logic        store_ovf;
  logic        save_go_next;
  logic        save_go_reg;
  logic        fact_reg;
  logic        fact_next;

  // Overflow judged only at the moment of a save
  assign store_ovf = save_cmd && (program_size > flash_capacity);

  always_comb
  begin
    flags_next = reset_cmd ? `STATUS_RESET : flags_reg;
    if (store_ovf)
      flags_next[`BIT_STORE_OVF] = 1'b1;
    else if (save_cmd)
      flags_next[`BIT_STORE_OVF] = 1'b0; // Clean save clears the old overflow
    if (buffer_ram_overflow_evt)
      flags_next[`BIT_BUFFER_OVF] = 1'b1;
    if (abort_sync_reg[1])
      flags_next[`BIT_ABORT_STOP] = 1'b1;
    if (missing_clock_evt)
      flags_next[`BIT_MISSING_CLOCK] = 1'b1;
    if (system_file_setting_evt)
      flags_next[`BIT_SYS_FILE] = 1'b1;
    if (saved_settings_evt)
      flags_next[`BIT_SAVED_SETTINGS] = 1'b1;
    if (project_read_evt)
      flags_next[`BIT_PROJECT_READ] = 1'b1;
    if (rt_watchdog_evt)
      flags_next[`BIT_SW_WDT_RT] = 1'b1;
    if (bg_watchdog_evt)
      flags_next[`BIT_SW_WDT_BG] = 1'b1;
    if (restore_reg)
      flags_next[`BIT_FACTORY_DEFAULT] = 1'b1;
    else if (save_cmd && !store_ovf)
      flags_next[`BIT_FACTORY_DEFAULT] = 1'b0; // Defaults become user settings
    // Disabled bits never hold a one
    flags_next[`BIT_EXP_HW_CHANGE] = 1'b0;
    flags_next[`BIT_EXP_CFG_HI:`BIT_EXP_CFG_LO] = 3'h0;
    flags_next[`BIT_HW_CHANGE] = 1'b0;
    flags_next[`BIT_STARTUP_READ] = 1'b0; // Derived below, not stored
    save_go_next = save_cmd && !store_ovf;
    fact_next    = restore_reg;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_reg   <= `STATUS_RESET;
      save_go_reg <= 1'b0;
      fact_reg    <= 1'b0;
    end
    else
    begin
      flags_reg   <= flags_next;
      save_go_reg <= save_go_next;
      fact_reg    <= fact_next;
    end
  end

  // Read view; writes on status_wr/status_wdata are deliberately discarded
  always_comb
  begin
    global_fault_status = {16'h0000, flags_reg};
    global_fault_status[`BIT_STARTUP_READ] =
      |flags_reg[`BIT_SYS_FILE:`BIT_PROJECT_READ];
  end

  assign save_go         = save_go_reg;
  assign factory_restore = fact_reg;

  logic unused_wr;
  assign unused_wr = status_wr ^ (^status_wdata);

endmodule

// File: rtl/fault_status_consts.svh
// Purpose: Bit positions, reset values and timing counts of the fault status word
// Assumes: Included by bare name from rtl files
// Notes:   Definitions only
`ifndef FAULT_STATUS_CONSTS_SVH
`define FAULT_STATUS_CONSTS_SVH

`define WORD_WIDTH          32
`define BIT_SW_WDT_BG       0
`define BIT_SW_WDT_RT       1
`define BIT_STARTUP_READ    2
`define BIT_PROJECT_READ    3
`define BIT_SAVED_SETTINGS  4
`define BIT_HW_CHANGE       5
`define BIT_SYS_FILE        6
`define BIT_FACTORY_DEFAULT 7
`define BIT_MISSING_CLOCK   8
`define BIT_ABORT_STOP      9
`define BIT_BUFFER_OVF      10
`define BIT_STORE_OVF       11
`define BIT_EXP_CFG_LO      12
`define BIT_EXP_CFG_HI      14
`define BIT_EXP_HW_CHANGE   15
`define STATUS_RESET        16'h0000
`define MARKER_SETTLE       2'h2

`endif

// File: rtl/fault_status_pkg.sv
// Purpose: Types for the fault status word
// Assumes: Constants come from fault_status_consts.svh
// Notes:   Startup sequence states only
package fault_status_pkg;
  typedef enum logic [1:0]
  {
    ST_STRAP  = 2'b00,
    ST_RESTORE = 2'b01,
    ST_RUN    = 2'b10
  } startup_state_t;
endpackage

// File: tb/controller_fault_status_word_properties.sv
// Purpose: Port checks of the fault status word
// Assumes: Bound into the status word module
// Notes:   Watches only the ports it needs
`timescale 1ns/1ns
module fault_status_properties
#(
  parameter int unsigned STORE_CAP_W = 24
)
(
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic                   reset_cmd,
  input wire logic                   save_cmd,
  input wire logic                   abort_all_in,
  input wire logic [STORE_CAP_W-1:0] program_size,
  input wire logic [STORE_CAP_W-1:0] flash_capacity,
  input wire logic                   project_read_evt,
  input wire logic                   bg_watchdog_evt,
  input wire logic [31:0]            global_fault_status,
  input wire logic                   save_go
);
  logic over;
  // Save refused when the program does not fit
  assign over = program_size > flash_capacity;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  upper_zero_a: assert property (global_fault_status[31:16] == 16'h0000)
    else $error("upper half not zero");
  exp_field_zero_a: assert property (global_fault_status[15:12] == 4'h0)
    else $error("expansion field not zero");
  hw_change_zero_a: assert property (!global_fault_status[5])
    else $error("hardware change bit set");
  startup_or_a: assert property (global_fault_status[2] == |global_fault_status[6:3])
    else $error("startup bit not OR of 3..6");
  project_set_a: assert property (project_read_evt |=> global_fault_status[3])
    else $error("project read bit missed");
  bg_wdt_set_a: assert property (bg_watchdog_evt |=> global_fault_status[0])
    else $error("background watchdog bit missed");
  // Pin crosses two sync flops, so three samples are needed
  abort_set_a: assert property (abort_all_in [*3] |=> global_fault_status[9])
    else $error("abort bit missed");
  abort_sticky_a: assert property (global_fault_status[9] && !reset_cmd |=> global_fault_status[9])
    else $error("abort bit dropped");
  store_ovf_a: assert property (save_cmd && over |=> global_fault_status[11] && !save_go)
    else $error("oversized save not refused");
  save_ok_a: assert property (save_cmd && !over |=> save_go)
    else $error("fitting save not carried out");
endmodule
bind controller_fault_status_word fault_status_properties
  #(.STORE_CAP_W(STORE_CAP_W)) chk_u (.*);

// File: tb/fault_host_model.sv
// Purpose: Host and operator side: save requests and reset medium
// Assumes: Driven 1 ns after the rising edge
// Notes:   Medium pin is changed only while power is off
`timescale 1ns/1ns
module fault_host_model
(
  input  wire logic clk,
  output logic        save_cmd,
  output logic [23:0] program_size,
  output logic [23:0] flash_capacity,
  output logic        marker_folder_present
);
  // Blank medium with the marker attached before power comes up
  initial
  begin
    save_cmd = 1'b0;
    program_size = 24'h000000;
    flash_capacity = 24'h000000;
    marker_folder_present = 1'b1;
  end
  // One-cycle save; sizes held afterwards so the pins never float
  task automatic do_save(input logic [23:0] size, input logic [23:0] cap);
    program_size = size;
    flash_capacity = cap;
    save_cmd = 1'b1;
    @(posedge clk);
    #1;
    save_cmd = 1'b0;
  endtask
endmodule

// File: tb/test_controller_fault_status_word.sv
// Purpose: Directed test of the fault status word
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   All waits are bounded
`timescale 1ns/1ns
module test_controller_fault_status_word;
  logic        clk, rst_n, reset_cmd, abort_all_in, status_wr, save_cmd;
  logic        marker, save_go, restore;
  logic [6:0]  ev;
  logic [23:0] psize, fcap;
  logic [31:0] wdata, word;
  int          n_fail = 0;
  int          n_checks = 0;
  int          bits[7] = '{10, 8, 6, 4, 3, 1, 0};
  controller_fault_status_word dut_u (.clk(clk), .rst_n(rst_n), .reset_cmd(reset_cmd),
    .marker_folder_present(marker), .abort_all_in(abort_all_in), .save_cmd(save_cmd),
    .program_size(psize), .flash_capacity(fcap), .buffer_ram_overflow_evt(ev[0]),
    .missing_clock_evt(ev[1]), .system_file_setting_evt(ev[2]),
    .saved_settings_evt(ev[3]), .project_read_evt(ev[4]), .rt_watchdog_evt(ev[5]),
    .bg_watchdog_evt(ev[6]), .status_wr(status_wr), .status_wdata(wdata),
    .global_fault_status(word), .save_go(save_go), .factory_restore(restore));
  fault_host_model host_u (.clk(clk), .save_cmd(save_cmd), .program_size(psize),
    .flash_capacity(fcap), .marker_folder_present(marker));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Reset command pulse; word must come back empty
  task automatic clear();
    reset_cmd = 1'b1;
    step(1);
    reset_cmd = 1'b0;
    chk("cleared", word, 32'h0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    {rst_n, reset_cmd, abort_all_in, status_wr, ev, wdata} = '0;
    step(12);
    rst_n = 1'b1;
    for (int i = 0; i < 8 && restore !== 1'b1; i++) step(1);
    if (restore !== 1'b1)
    begin
      n_fail++;
      end_of_test();
    end
    chk("default", word, 32'h80);
    host_u.do_save(24'h000100, 24'h000100);
    chk("save_go", save_go, 32'h1);
    chk("saved", word, 32'h0);
    host_u.do_save(24'h000101, 24'h000100);
    chk("save_go", save_go, 32'h0);
    {status_wr, wdata} = {1'b1, 32'hFFFFFFFF};
    step(1);
    status_wr = 1'b0;
    chk("overflow", word, 32'h800);
    clear();
    // Each event alone, bit 2 follows bits 3..6
    for (int i = 0; i < 7; i++)
    begin
      ev = 7'h01 << i;
      step(1);
      ev = 7'h00;
      chk("event", word, (32'h1 << bits[i]) | ((bits[i] inside {[3:6]}) ? 32'h4 : 32'h0));
      clear();
    end
    abort_all_in = 1'b1;
    step(4);
    abort_all_in = 1'b0;
    step(4);
    chk("abort", word, 32'h200);
    clear();
    host_u.marker_folder_present = 1'b0;
    rst_n = 1'b0;
    step(2);
    chk("power off", word, 32'h0);
    rst_n = 1'b1;
    step(5);
    chk("no marker", word, 32'h0);
    end_of_test();
  end
endmodule
